/* rtl/cnsd_pkg.sv */
// constants for the node switch decoder
// =====================================================
// What this block does
// - address switches form 3-bit address, bit0 lowest
// - all-zero code selects software address, default 1
// - baud switch zero: software rate; one: 500k
// - single axis: termination switch one connects 120 ohm
// - dual axis: switches four-six give axis two address
// - dual axis: baud choice from switch seven
// - dual axis: switch eight zero open, one terminated
package cnsd_pkg;
    // =====================================================
    // switch vector layout
    localparam int SW_W          = 8;
    localparam int SW_A1_LSB     = 0;  // addr_sw_bit0..2
    localparam int SW_A2_LSB     = 3;  // switch_four..six
    localparam int SW_S_BAUD     = 3;  // single: switch_four
    localparam int SW_S_TERM     = 4;  // single: switch_five
    localparam int SW_D_BAUD     = 6;  // dual_baud_select
    localparam int SW_D_TERM     = 7;  // dual_term_select
    // =====================================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_NS     = 10000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // =====================================================
    // register map and fields
    localparam logic [7:0]  CFG_OFS      = 8'h00;
    localparam logic [7:0]  STAT_OFS     = 8'h04;
    localparam int          F_A1_LSB     = 0;
    localparam int          F_A2_LSB     = 4;
    localparam int          F_RATE_LSB   = 8;
    localparam int          F_TERM_BIT   = 12;
    localparam int          F_VALID_BIT  = 16;
    localparam int          F_SW_LSB     = 24;
    localparam logic [2:0]  ADDR_DEF     = 3'h1;
    localparam logic [2:0]  ADDR_NONE    = 3'h0;
    localparam logic [1:0]  RATE_1M      = 2'h0;
    localparam logic [1:0]  RATE_500K    = 2'h1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [31:0] CFG_RST      = 32'h0000_0011;
    // settle states
    typedef enum logic [0:0] {ST_SETTLE, ST_LOCKED} cnsd_state_t;
endpackage

/* rtl/cnsd_sw_if.sv */
// carrier for the filtered switch vector
`timescale 1ns/1ps
interface cnsd_sw_if;
    logic [cnsd_pkg::SW_W-1:0] sw;  // filtered switch levels
    modport src (output sw);
    modport dst (input sw);
endinterface

/* rtl/cnsd_sync.sv */
// three-flop switch synchroniser with agreement filter
`timescale 1ns/1ps
module cnsd_sync import cnsd_pkg::*; (
    // clock and reset
    input wire logic            ref_clk,
    input wire logic            rst,
    // raw switch pins
    input wire logic [SW_W-1:0] raw,
    // filtered output
    cnsd_sw_if.src              out
);
    logic [SW_W-1:0] s1;
    logic [SW_W-1:0] s2;
    logic [SW_W-1:0] s3;
    logic [SW_W-1:0] q;

    assign out.sw = q;

    // one chain per switch; a level counts once stages two and three agree
    genvar i;
    for (i = 0; i < SW_W; i++) begin : g_bit
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                s1[i] <= 1'b0;
                s2[i] <= 1'b0;
                s3[i] <= 1'b0;
                q[i]  <= 1'b0;
            end else begin
                s1[i] <= raw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    end
endmodule

/* rtl/cnsd_top.sv */
// switch bank decoder for CAN node settings with AXI4-Lite registers
`timescale 1ns/1ps
module cnsd_top import cnsd_pkg::*; #(
    parameter bit DUAL_AXIS = 1'b0
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // switch pins
    input  wire logic        addr_sw_bit0,
    input  wire logic        addr_sw_bit1,
    input  wire logic        addr_sw_bit2,
    input  wire logic        switch_four,
    input  wire logic        switch_five,
    input  wire logic        switch_six,
    input  wire logic        dual_baud_select,
    input  wire logic        dual_term_select,
    // decoded settings to the protocol logic
    output logic [2:0]       node_addr_a1,
    output logic [2:0]       node_addr_a2,
    output logic [1:0]       bit_rate,
    output logic             term_en,
    output logic             cfg_valid,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    cnsd_sw_if   swi ();
    cnsd_state_t state;
    logic [SW_W-1:0] sw_prev;
    logic [SW_W-1:0] sw_lat;
    logic [7:0]      cnt;
    logic [2:0]      cfg_a1;
    logic [2:0]      cfg_a2;
    logic [1:0]      cfg_rate;
    logic            aw_held;
    logic            w_held;
    logic [7:0]      awaddr_q;
    logic [31:0]     wdata_q;
    logic [3:0]      wstrb_q;
    logic            aw_take;
    logic            w_take;
    logic            ar_take;
    logic            wr_fire;
    logic            next_aw_held;
    logic            next_w_held;
    logic            next_bvalid;
    logic            next_rvalid;
    logic [2:0]      sw_a1;
    logic [2:0]      sw_a2;
    logic            sw_baud;
    logic            sw_term;

    // =====================================================
    // switch synchronisation
    cnsd_sync u_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .raw     ({dual_term_select, dual_baud_select, switch_six, switch_five,
                   switch_four, addr_sw_bit2, addr_sw_bit1, addr_sw_bit0}),
        .out     (swi.src)
    );

    // =====================================================
    // settle and lock
    // lock after a quiet period
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state   <= ST_SETTLE;
            cnt     <= 8'h00;
            sw_prev <= 8'h00;
            sw_lat  <= 8'h00;
        end else begin
            sw_prev <= swi.sw;
            case (state)
                ST_SETTLE: begin
                    if (swi.sw != sw_prev) begin
                        cnt <= 8'h00;  // restart on any bounce
                    end else if (cnt == 8'(SETTLE_CYC - 1)) begin
                        sw_lat <= swi.sw;
                        state  <= ST_LOCKED;
                    end else begin
                        cnt <= cnt + 8'h01;
                    end
                end
                ST_LOCKED: state <= ST_LOCKED;  // held until reset
                default:   state <= ST_SETTLE;
            endcase
        end
    end

    // =====================================================
    // decode of the latched bank
    // lowest switch is bit zero
    assign sw_a1 = sw_lat[SW_A1_LSB +: 3];
    // axis two from switches four to six
    assign sw_a2 = sw_lat[SW_A2_LSB +: 3];
    // baud bit moves with the variant
    assign sw_baud = DUAL_AXIS ? sw_lat[SW_D_BAUD] : sw_lat[SW_S_BAUD];
    // termination bit moves with the variant
    assign sw_term = DUAL_AXIS ? sw_lat[SW_D_TERM] : sw_lat[SW_S_TERM];

    // settings presented to protocol logic once locked
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            node_addr_a1 <= ADDR_DEF;
            node_addr_a2 <= ADDR_NONE;
            bit_rate     <= RATE_1M;
            term_en      <= 1'b0;
            cfg_valid    <= 1'b0;
        end else begin
            cfg_valid <= (state == ST_LOCKED);
            if (state == ST_LOCKED) begin
                // zero code falls back to software
                node_addr_a1 <= (sw_a1 == 3'h0) ? cfg_a1 : sw_a1;
                if (DUAL_AXIS) begin
                    node_addr_a2 <= (sw_a2 == 3'h0) ? cfg_a2 : sw_a2;
                end else begin
                    node_addr_a2 <= ADDR_NONE;
                end
                bit_rate <= sw_baud ? RATE_500K : cfg_rate;
                // one connects the 120 ohm load
                term_en  <= sw_term;
            end
        end
    end

    // =====================================================
    // axi4-lite write channel
    assign aw_take      = s_axi_awvalid && s_axi_awready;
    assign w_take       = s_axi_wvalid && s_axi_wready;
    assign wr_fire      = aw_held && w_held && !s_axi_bvalid;
    assign next_aw_held = (aw_held || aw_take) && !wr_fire;
    assign next_w_held  = (w_held || w_take) && !wr_fire;
    assign next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);

    // address and data are taken in either order, answered together
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bresp <= (awaddr_q[7:2] == CFG_OFS[7:2] ||
                                awaddr_q[7:2] == STAT_OFS[7:2]) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // software fallback values, byte-lane gated
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_a1   <= CFG_RST[F_A1_LSB +: 3];
            cfg_a2   <= CFG_RST[F_A2_LSB +: 3];
            cfg_rate <= CFG_RST[F_RATE_LSB +: 2];
        end else if (wr_fire && awaddr_q[7:2] == CFG_OFS[7:2]) begin
            if (wstrb_q[0]) begin
                cfg_a1 <= wdata_q[F_A1_LSB +: 3];
                cfg_a2 <= wdata_q[F_A2_LSB +: 3];
            end
            if (wstrb_q[1]) begin
                cfg_rate <= wdata_q[F_RATE_LSB +: 2];
            end
        end
    end

    // =====================================================
    // axi4-lite read channel
    assign ar_take     = s_axi_arvalid && s_axi_arready;
    assign next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

    // one-cycle read answer; status shows the locked decode and the latched bank
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr[7:2] == CFG_OFS[7:2]) begin
                    s_axi_rdata[F_A1_LSB +: 3]   <= cfg_a1;
                    s_axi_rdata[F_A2_LSB +: 3]   <= cfg_a2;
                    s_axi_rdata[F_RATE_LSB +: 2] <= cfg_rate;
                end else if (s_axi_araddr[7:2] == STAT_OFS[7:2]) begin
                    s_axi_rdata[F_A1_LSB +: 3]   <= node_addr_a1;
                    s_axi_rdata[F_A2_LSB +: 3]   <= node_addr_a2;
                    s_axi_rdata[F_RATE_LSB +: 2] <= bit_rate;
                    s_axi_rdata[F_TERM_BIT]      <= term_en;
                    s_axi_rdata[F_VALID_BIT]     <= cfg_valid;
                    s_axi_rdata[F_SW_LSB +: 8]   <= sw_lat;
                end else begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
        end
    end

    // =====================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    addr1_switch_a: assert property ((state == ST_LOCKED) && sw_a1 != 3'h0 |=>
        node_addr_a1 == $past(sw_a1)) else $error("axis one address not from switches");
    addr1_soft_a: assert property ((state == ST_LOCKED) && sw_a1 == 3'h0 |=>
        node_addr_a1 == $past(cfg_a1)) else $error("axis one fallback wrong");
    rate_select_a: assert property ((state == ST_LOCKED) |=>
        bit_rate == ($past(sw_baud) ? RATE_500K : $past(cfg_rate)))
        else $error("bit rate wrong");
    term_single_a: assert property (!DUAL_AXIS && (state == ST_LOCKED) |=>
        term_en == $past(sw_lat[SW_S_TERM])) else $error("single termination wrong");
    addr2_decode_a: assert property (DUAL_AXIS && (state == ST_LOCKED) |=>
        node_addr_a2 == (($past(sw_a2) == 3'h0) ? $past(cfg_a2) : $past(sw_a2)))
        else $error("axis two address wrong");
    baud_dual_a: assert property (DUAL_AXIS && cfg_valid && sw_lat[SW_D_BAUD]
        |-> bit_rate == RATE_500K) else $error("dual baud switch ignored");
    term_dual_a: assert property (DUAL_AXIS && cfg_valid |->
        term_en == sw_lat[SW_D_TERM]) else $error("dual termination wrong");
    lock_hold_a: assert property (cfg_valid |=> cfg_valid && $stable(sw_lat))
        else $error("lock lost or latch moved");
    settle_quiet_a: assert property ($rose(cfg_valid) |->
        $past(swi.sw, 2) == sw_lat && $past(swi.sw, 3) == sw_lat)
        else $error("locked on moving switches");
    write_resp_a: assert property (aw_take && w_take |-> ##2 s_axi_bvalid)
        else $error("write answer late");

    lock_seen_c:   cover property ($rose(cfg_valid));
    soft_addr_c:   cover property (cfg_valid && sw_a1 == 3'h0);
    forced_rate_c: cover property (cfg_valid && bit_rate == RATE_500K);
    cfg_write_c:   cover property (wr_fire && awaddr_q[7:2] == CFG_OFS[7:2]);
endmodule

/* dv/cnsd_sw_bank.sv */
// switch bank model: drives the pins, with contact bounce after each change
`timescale 1ns/1ps
module cnsd_sw_bank #(
    parameter int BOUNCE = 30
) (
    // clock
    input  wire logic       ref_clk,
    // wanted lever positions and the pins they drive
    input  wire logic [7:0] setting,
    output logic      [7:0] pins
);
    logic [7:0] last = 8'h00;
    int         left = 0;
    // =====================================================
    // bounce: pins flip every cycle for a while, then follow the levers
    always @(posedge ref_clk) begin
        if (setting !== last) begin
            last <= setting;
            left <= BOUNCE;
        end else if (left > 0) begin
            left <= left - 1;
        end
        pins <= (left > 0) ? ~pins : last;  // never a clean level while bouncing
    end
endmodule

/* dv/tb.sv */
// self-checking bench for the node switch decoder
`timescale 1ns/1ps
module tb;
    import cnsd_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  sw_set  = 8'h00;
    logic [7:0]  pins;
    logic [2:0]  a1, a2;
    logic [2:0]  soft_a1 = 3'h1, soft_a2 = 3'h1;
    logic [1:0]  soft_rate = 2'h0;
    logic [1:0]  rate, bresp, rresp;
    logic        term, cfg_valid, v_q;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, d;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    logic [17:0] exp_o[$];
    logic [8:0]  sgl;  // single-axis decode: a1, a2, rate, term
    logic [31:0] seed = 32'h0000_3ff9;
    int          failures = 0, checks_done = 0, cyc = 0;
    // =====================================================
    // clock, switch bank and design
    initial forever #25 ref_clk = ~ref_clk;
    cnsd_sw_bank BANK (.ref_clk(ref_clk), .setting(sw_set), .pins(pins));
    cnsd_top #(.DUAL_AXIS(1'b1)) DUT (
        .ref_clk(ref_clk), .rst(rst),
        .addr_sw_bit0(pins[0]), .addr_sw_bit1(pins[1]), .addr_sw_bit2(pins[2]),
        .switch_four(pins[3]), .switch_five(pins[4]), .switch_six(pins[5]),
        .dual_baud_select(pins[6]), .dual_term_select(pins[7]),
        .node_addr_a1(a1), .node_addr_a2(a2), .bit_rate(rate),
        .term_en(term), .cfg_valid(cfg_valid),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    // single-axis variant on the same pins; its bus stays idle
    cnsd_top #(.DUAL_AXIS(1'b0)) DUT_SINGLE (
        .ref_clk(ref_clk), .rst(rst),
        .addr_sw_bit0(pins[0]), .addr_sw_bit1(pins[1]), .addr_sw_bit2(pins[2]),
        .switch_four(pins[3]), .switch_five(pins[4]), .switch_six(pins[5]),
        .dual_baud_select(pins[6]), .dual_term_select(pins[7]),
        .node_addr_a1(sgl[8:6]), .node_addr_a2(sgl[5:3]), .bit_rate(sgl[2:1]),
        .term_en(sgl[0]), .cfg_valid(),
        .s_axi_awaddr(8'h00), .s_axi_awvalid(1'b0), .s_axi_awready(),
        .s_axi_wdata(32'h0000_0000), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(1'b0), .s_axi_araddr(8'h00), .s_axi_arvalid(1'b0),
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready(1'b0)
    );
    // =====================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // zero code falls back to software values
    function automatic logic [8:0] dec(input logic [7:0] s);
        logic [2:0] x1, x2;
        x1 = (s[2:0] != 3'h0) ? s[2:0] : soft_a1;
        x2 = (s[5:3] != 3'h0) ? s[5:3] : soft_a2;
        return {x1, x2, (s[6] ? RATE_500K : soft_rate), s[7]};
    endfunction
    // single axis: switch_four baud, switch_five termination
    function automatic logic [8:0] dec1(input logic [7:0] s);
        return {((s[2:0] != 3'h0) ? s[2:0] : ADDR_DEF), ADDR_NONE,
                (s[3] ? RATE_500K : RATE_1M), s[4]};
    endfunction
    function automatic logic [31:0] stat(input logic [7:0] s);
        logic [8:0] e;
        e = dec(s);
        return {s, 7'h00, 1'b1, 3'h0, e[0], 2'h0, e[2:1], 1'b0, e[5:3], 1'b0, e[8:6]};
    endfunction
    task automatic check(input string what, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // =====================================================
    // register bus master: hold each channel until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        exp_b.push_back(e);
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] v);
        exp_r.push_back({e, v});
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    // reset with new levers, then wait for the settings to lock
    task automatic lock(input logic [7:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        rst       <= 1'b1;
        sw_set    <= s;
        soft_a1   = 3'h1;
        soft_a2   = 3'h1;
        soft_rate = RATE_1M;
        repeat (6) @(posedge ref_clk);
        exp_o.push_back({dec(s), dec1(s)});
        rst <= 1'b0;
        while (cfg_valid !== 1'b1 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
        check("settle", 34'h1, {33'h0, (n >= 200 && n < 600)});
        rd(STAT_OFS, RESP_OKAY, stat(s));
    endtask
    // =====================================================
    // watcher: compare each result against the oldest note
    always @(posedge ref_clk) begin
        cyc++;
        if (rvalid === 1'b1 && rready === 1'b1)
            check("read", exp_r.pop_front(), {rresp, rdata});
        if (bvalid === 1'b1 && bready === 1'b1)
            check("bresp", exp_b.pop_front(), bresp);
        if (cfg_valid === 1'b1 && v_q !== 1'b1)
            check("decoded", exp_o.pop_front(),
                  {a1, a2, rate, term, sgl});
        v_q <= cfg_valid;
        // limit reached: count it and close the run
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    // =====================================================
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        check("reset", {24'h0, ADDR_DEF, ADDR_NONE, RATE_1M, 2'b00},
              {a1, a2, rate, term, cfg_valid});
        lock(8'hff);
        for (int i = 0; i < 3; i++) begin
            d = xs();
            lock(d[7:0]);
        end
        for (int k = 0; k < 3; k++) begin
            lock(k == 0 ? 8'h00 : (k == 1 ? 8'h40 : 8'h8a));
            for (int i = 0; i < 4; i++) begin
                d = xs();
                wr(CFG_OFS, d, RESP_OKAY);
                soft_a1   = d[2:0];
                soft_a2   = d[6:4];
                soft_rate = d[9:8];
                rd(CFG_OFS, RESP_OKAY, d & 32'h0000_0377);
                rd(STAT_OFS, RESP_OKAY, stat(sw_set));
            end
            wr(STAT_OFS, 32'hffff_ffff, RESP_OKAY);
            wr(8'h08, 32'h0000_0000, RESP_SLVERR);
            rd(8'h0c, RESP_SLVERR, 32'h0000_0000);
            rd(CFG_OFS, RESP_OKAY, d & 32'h0000_0377);
            d[7:0] = sw_set;
            sw_set <= ~sw_set;
            repeat (260) @(posedge ref_clk);
            rd(STAT_OFS, RESP_OKAY, stat(d[7:0]));
        end
        give_verdict();
    end
endmodule
